// ### hw/apl_config_regs.sv
// Register slice holding power and readout link configuration.
`timescale 1ns/100ps
// How it works
// - Power bit 5 set turns off the half-reference output buffer.
// - Power bit 3 set turns off channel B and its reference buffer.
// - Power bit 1 set turns off channel A and its reference buffer.
// - Power bit 0 set turns off the internal voltage reference.
// - Reserved bits read zero and host writes to them are masked off.
// - Protocol code 000 picks SPI single rate, 001 SPI double rate.
// - Protocol code 010 picks re-timer single rate, 011 double rate.
// - Any protocol code with top bit one picks parallel byte readout.
// - Protocol bit 1 gives the serial clock polarity for both parties.
// - Protocol bit 0 gives the serial clock phase for both parties.
// - Lane code 00 or 01 is one line, 10 two lines, 11 four lines.
// - Parallel byte readout ignores the lane code and uses all eight lines.
// - All four registers reset to zero.
// - Strobe source code picks serial clock, internal, half or quarter.
module apl_config_regs
	import apl_pkg::*;
#(
	parameter int ADDR_W = APL_ADDR_W
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Frame boundary from the readout framer, same clock.
	input wire logic frame_start,
	// Controls toward the analogue section and the framer.
	output apl_power_s power_ctrl,
	output apl_link_s link_cfg
);
	// ==========================================================
	// Elaboration checks.
	if (ADDR_W < APL_ADDR_W) begin : g_chk
		$error("ADDR_W too small for the register map");
	end

	// All state of the module.
	typedef struct packed {
		logic [7:0] pwr;
		logic [7:0] proto;
		logic [7:0] lane;
		logic [7:0] retimer;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		apl_link_s link;
		logic pend;
	} apl_state_s;

	apl_state_s st_ff;
	apl_state_s nxt_st;

	// ==========================================================
	// Helper functions.
	// Word index from a byte address; misaligned gives no match.
	function automatic logic [3:0] word_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] s;
		s = a >> APL_BYTE_SHIFT;
		word_idx = (a[1:0] != 2'h0 || s > 'hf) ? 4'hf : s[3:0];
	endfunction

	// Decode the three-bit protocol code into a framing mode.
	function automatic apl_frame_e decode_mode(input logic [2:0] c);
		if (c[2]) begin
			decode_mode = APL_FR_PAR;
		end else begin
			case (c[1:0])
				2'h0: decode_mode = APL_FR_SPI_SDR;
				2'h1: decode_mode = APL_FR_SPI_DDR;
				2'h2: decode_mode = APL_FR_RTM_SDR;
				default: decode_mode = APL_FR_RTM_DDR;
			endcase
		end
	endfunction

	// Lanes in use: four per converter split as A low, B high nibble.
	function automatic logic [7:0] lanes(input apl_frame_e m,
			input logic [1:0] w);
		if (m == APL_FR_PAR) begin
			lanes = 8'hff;
		end else begin
			case (w)
				2'h2: lanes = 8'h33;
				2'h3: lanes = 8'hff;
				default: lanes = 8'h11;
			endcase
		end
	endfunction

	// Merge byte lane 0 into a register under its writable mask.
	function automatic logic [7:0] merge(input logic [7:0] old,
			input logic [7:0] d, input logic [7:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// Build the link setting from the register contents.
	function automatic apl_link_s build_link(input logic [7:0] p,
			input logic [7:0] l, input logic [7:0] c);
		apl_link_s r;
		r.mode = decode_mode(p[APL_B_PROTO_LO +: 3]);
		r.serial_clock_polarity = p[APL_B_CPOL];
		r.serial_clock_phase = p[APL_B_CPHA];
		r.lane_enable = lanes(r.mode, l[1:0]);
		r.strobe_clock_source = apl_stb_e'(c[1:0]);
		build_link = r;
	endfunction

	// ==========================================================
	// Next-state logic for the bus slave and the registers.
	logic do_write;
	logic do_read;
	logic [3:0] widx;
	logic [3:0] ridx;
	logic [31:0] rword;
	logic wok;
	apl_link_s staged;

	always_comb begin
		nxt_st = st_ff;
		do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
		do_read = s_axi_arvalid && !st_ff.rvalid;
		widx = word_idx(st_ff.aw_addr);
		ridx = word_idx(s_axi_araddr);
		wok = 1'b1;
		rword = 32'h0000_0000;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		// Only lane 0 carries data; other strobes are harmless.
		if (do_write) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			if (st_ff.w_strb[0]) begin
				case (widx)
					APL_IDX_PWR: nxt_st.pwr = merge(st_ff.pwr,
						st_ff.w_data[7:0], APL_MASK_PWR);
					APL_IDX_PROTO: nxt_st.proto = merge(st_ff.proto,
						st_ff.w_data[7:0], APL_MASK_PROTO);
					APL_IDX_LANE: nxt_st.lane = merge(st_ff.lane,
						st_ff.w_data[7:0], APL_MASK_LANE);
					APL_IDX_RETIMER: nxt_st.retimer = merge(st_ff.retimer,
						st_ff.w_data[7:0], APL_MASK_RETIMER);
					APL_IDX_FRAME: wok = 1'b0;
					default: wok = 1'b0;
				endcase
			end else begin
				wok = (widx == APL_IDX_PWR) || (widx == APL_IDX_PROTO)
					|| (widx == APL_IDX_LANE) || (widx == APL_IDX_RETIMER);
			end
			nxt_st.bresp = wok ? APL_RESP_OKAY : APL_RESP_SLVERR;
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Read mux; the frame word shows the setting in force.
		case (ridx)
			APL_IDX_PWR: rword = {24'h0, st_ff.pwr};
			APL_IDX_PROTO: rword = {24'h0, st_ff.proto};
			APL_IDX_LANE: rword = {24'h0, st_ff.lane};
			APL_IDX_RETIMER: rword = {24'h0, st_ff.retimer};
			APL_IDX_FRAME: rword = {14'h0, st_ff.pend, st_ff.link};
			default: rword = 32'h0000_0000;
		endcase
		// Unmapped words answer SLVERR so a host that strays learns of it.
		if (do_read) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rword;
			nxt_st.rresp = (ridx <= APL_IDX_RETIMER && ridx >= APL_IDX_PWR)
				|| ridx == APL_IDX_FRAME ? APL_RESP_OKAY : APL_RESP_SLVERR;
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		// Stage the new setting; swap it in only at a frame edge.
		// Swapping mid-frame would split one word across two lane counts.
		staged = build_link(nxt_st.proto, nxt_st.lane, nxt_st.retimer);
		nxt_st.pend = (staged != st_ff.link);
		if (frame_start) begin
			nxt_st.link = build_link(st_ff.proto, st_ff.lane,
				st_ff.retimer);
			nxt_st.pend = (staged != nxt_st.link);
		end
	end

	// State register; everything but the link setting clears to zero on reset; the link takes the setting built from zero registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.link <= build_link(APL_RST_VAL, APL_RST_VAL,
				APL_RST_VAL);
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs.
	assign s_axi_awready = !st_ff.aw_held;
	assign s_axi_wready = !st_ff.w_held;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	// Power controls act at once; no frame is involved.
	// One assignment drives the whole struct so it has a single driver.
	assign power_ctrl = '{
		half_ref_output_off: st_ff.pwr[APL_B_HALFREF],
		channel_b_off: st_ff.pwr[APL_B_CHB],
		channel_a_off: st_ff.pwr[APL_B_CHA],
		internal_reference_off: st_ff.pwr[APL_B_IREF]
	};
	assign link_cfg = st_ff.link;

	// ==========================================================
	// Assertions.
	pwr_reserved_zero_a: assert property (@(posedge aclk)
		disable iff (!aresetn) (st_ff.pwr & ~APL_MASK_PWR) == 8'h00)
		else $error("reserved power bits set");
	proto_reserved_zero_a: assert property (@(posedge aclk)
		disable iff (!aresetn)
		((st_ff.proto & ~APL_MASK_PROTO) | (st_ff.lane & ~APL_MASK_LANE)
		| (st_ff.retimer & ~APL_MASK_RETIMER)) == 8'h00)
		else $error("reserved config bits set");
	par_all_lanes_a: assert property (@(posedge aclk)
		disable iff (!aresetn) link_cfg.mode == APL_FR_PAR
		|-> link_cfg.lane_enable == 8'hff)
		else $error("parallel mode without all lanes");
	link_stable_a: assert property (@(posedge aclk)
		disable iff (!aresetn) !$past(frame_start)
		|-> $stable(link_cfg))
		else $error("link setting changed mid frame");
	link_follows_a: assert property (@(posedge aclk)
		disable iff (!aresetn) frame_start ##1 1'b1 |->
		link_cfg.mode
		== decode_mode($past(st_ff.proto[APL_B_PROTO_LO +: 3])))
		else $error("framing mode mismatch");
	polarity_take_a: assert property (@(posedge aclk)
		disable iff (!aresetn) frame_start |=> link_cfg
		.serial_clock_polarity == $past(st_ff.proto[APL_B_CPOL]))
		else $error("polarity not applied");
	phase_take_a: assert property (@(posedge aclk)
		disable iff (!aresetn) frame_start |=> link_cfg
		.serial_clock_phase == $past(st_ff.proto[APL_B_CPHA]))
		else $error("phase not applied");
	reset_zero_a: assert property (@(posedge aclk)
		!aresetn |=> st_ff.pwr == 8'h00 && st_ff.proto == 8'h00)
		else $error("registers not cleared by reset");
	chb_follow_a: assert property (@(posedge aclk)
		disable iff (!aresetn) do_write && widx == APL_IDX_PWR
		&& st_ff.w_strb[0] |=> power_ctrl.channel_b_off
		== $past(st_ff.w_data[APL_B_CHB]))
		else $error("channel b control mismatch");
	write_resp_a: assert property (@(posedge aclk)
		disable iff (!aresetn) do_write |=> s_axi_bvalid)
		else $error("write response missing");
	strobe_take_a: assert property (@(posedge aclk)
		disable iff (!aresetn) frame_start |=>
		link_cfg.strobe_clock_source
		== apl_stb_e'($past(st_ff.retimer[1:0])))
		else $error("strobe source not applied");
	frame_write_err_a: assert property (@(posedge aclk)
		disable iff (!aresetn) do_write && widx == APL_IDX_FRAME
		|=> s_axi_bresp == APL_RESP_SLVERR)
		else $error("frame word write not refused");
	cov_par_c: cover property (@(posedge aclk) link_cfg.mode == APL_FR_PAR);
	cov_quad_c: cover property (@(posedge aclk)
		link_cfg.mode == APL_FR_SPI_DDR && link_cfg.lane_enable == 8'hff);
	cov_pend_c: cover property (@(posedge aclk) st_ff.pend ##1 frame_start);
	cov_rtm_ddr_c: cover property (@(posedge aclk)
		link_cfg.mode == APL_FR_RTM_DDR);
	cov_slverr_c: cover property (@(posedge aclk)
		s_axi_bvalid && s_axi_bresp == APL_RESP_SLVERR);
endmodule

// ### inc/apl_pkg.sv
// Package of constants and types for the converter power and link config.
package apl_pkg;
	// ==========================================================
	// Register indices and byte addresses
	localparam logic [3:0] APL_IDX_PWR = 4'h1;
	localparam logic [3:0] APL_IDX_PROTO = 4'h2;
	localparam logic [3:0] APL_IDX_LANE = 4'h3;
	localparam logic [3:0] APL_IDX_RETIMER = 4'h4;
	localparam logic [3:0] APL_IDX_FRAME = 4'h8;
	localparam int APL_ADDR_W = 6;
	localparam int APL_BYTE_SHIFT = 2;
	// ==========================================================
	// Writable bit masks; reserved positions stay zero.
	localparam logic [7:0] APL_MASK_PWR = 8'h2b;
	localparam logic [7:0] APL_MASK_PROTO = 8'h73;
	localparam logic [7:0] APL_MASK_LANE = 8'h03;
	localparam logic [7:0] APL_MASK_RETIMER = 8'h03;
	localparam logic [7:0] APL_RST_VAL = 8'h00;
	// ==========================================================
	// Field positions.
	localparam int APL_B_HALFREF = 5;
	localparam int APL_B_CHB = 3;
	localparam int APL_B_CHA = 1;
	localparam int APL_B_IREF = 0;
	localparam int APL_B_PROTO_LO = 4;
	localparam int APL_B_CPOL = 1;
	localparam int APL_B_CPHA = 0;
	// ==========================================================
	// AXI response codes.
	localparam logic [1:0] APL_RESP_OKAY = 2'h0;
	localparam logic [1:0] APL_RESP_SLVERR = 2'h2;

	// Decoded framing modes.
	typedef enum logic [4:0] {
		APL_FR_SPI_SDR = 5'h01,
		APL_FR_SPI_DDR = 5'h02,
		APL_FR_RTM_SDR = 5'h04,
		APL_FR_RTM_DDR = 5'h08,
		APL_FR_PAR = 5'h10
	} apl_frame_e;

	// Strobe clock sources.
	typedef enum logic [1:0] {
		APL_STB_SCLK = 2'h0,
		APL_STB_INT = 2'h1,
		APL_STB_INT2 = 2'h2,
		APL_STB_INT4 = 2'h3
	} apl_stb_e;

	// Power controls toward the analogue section.
	typedef struct packed {
		logic half_ref_output_off;
		logic channel_b_off;
		logic channel_a_off;
		logic internal_reference_off;
	} apl_power_s;

	// Link setting that is applied frame by frame.
	typedef struct packed {
		apl_frame_e mode;
		logic serial_clock_polarity;
		logic serial_clock_phase;
		logic [7:0] lane_enable;
		apl_stb_e strobe_clock_source;
	} apl_link_s;
endpackage

// ### tb/apl_framer_model.sv
// Readout framer stand-in that marks frame edges and samples the link setting.
`timescale 1ns/100ps
module apl_framer_model
	import apl_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Frame request from the bench and frame edge toward the block.
	input wire logic req,
	output logic frame_start,
	// Link setting as the framer uses it for the frame.
	input wire apl_link_s link_cfg,
	output apl_link_s seen
);
	logic [1:0] dly_ff;

	// ==========================================================
	// Frame edge
	// One pulse per request; the setting is taken two edges later so that
	// either reading of the apply edge is covered.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_start <= 1'b0;
			dly_ff <= 2'h0;
			seen <= '0;
		end else begin
			frame_start <= req;
			dly_ff <= {dly_ff[0], frame_start};
			if (dly_ff[1]) begin
				seen <= link_cfg;
			end
		end
	end
endmodule

// ### tb/adc_power_and_link_config_tb_top.sv
// Self-checking bench for the power and link configuration registers.
`timescale 1ns/100ps
module adc_power_and_link_config_tb_top
	import apl_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, req = 1'b0, fs;
	logic [5:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, ta, tw;
	logic [1:0] bresp, rresp, r;
	logic [31:0] d;
	apl_power_s pwr;
	apl_link_s lk, seen;
	int bad_count = 0, checked = 0;
	logic [3:0] wstrb = 4'h1;
	// Link word after reset: SPI single rate, one lane per converter.
	localparam logic [31:0] LINK_RST = 32'h0000_1044;

	// ==========================================================
	// Clock, device and framer
	initial forever #5 aclk = ~aclk;
	apl_config_regs u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .frame_start(fs), .power_ctrl(pwr),
		.link_cfg(lk));
	apl_framer_model u_frm (.aclk(aclk), .aresetn(aresetn), .req(req),
		.frame_start(fs), .link_cfg(lk), .seen(seen));

	// ==========================================================
	// Bus tasks; ready and answers are sampled on the falling edge, where
	// they are settled, and acted on at the following rising edge.
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!(ta || !awvalid) || !(tw || !wvalid));
		do @(negedge aclk); while (!bvalid);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// One frame edge, then time for the setting to be applied and seen.
	task automatic frame();
		@(posedge aclk);
		req <= 1'b1;
		@(posedge aclk);
		req <= 1'b0;
		repeat (6) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		for (int i = 1; i <= 4; i++) begin
			rd(6'(i * 4));
			chk(d, 32'h0);
		end
		chk(32'(lk), LINK_RST);
		rd(6'h20);
		chk(d, LINK_RST);
		chk(32'(pwr), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_power();
		wr(6'h04, 32'h2b);
		rd(6'h04);
		chk(d, 32'h2b);
		chk(32'(pwr), 32'hf);
		wr(6'h04, 32'h22);
		chk(32'(pwr), 32'ha);
		wr(6'h04, 32'h09);
		chk(32'(pwr), 32'h5);
		$display("test power done");
	endtask

	task automatic t_proto();
		logic [4:0] m;
		m = 5'h01;
		for (int p = 0; p < 8; p++) begin
			wr(6'h08, 32'((p << 4) | (p & 3)));
			rd(6'h08);
			chk(d, 32'((p << 4) | (p & 3)));
			chk(32'(lk.mode), 32'(m));
			m = (p < 4) ? 5'(1 << p) : 5'h10;
			frame();
			chk(32'(seen.mode), 32'(m));
			chk(32'(seen.serial_clock_polarity), 32'(p[1]));
			chk(32'(seen.serial_clock_phase), 32'(p[0]));
		end
		$display("test protocol done");
	endtask

	task automatic t_lane();
		logic [7:0] le [4] = '{8'h11, 8'h11, 8'h33, 8'hff};
		wr(6'h08, 32'h10);
		for (int l = 0; l < 4; l++) begin
			wr(6'h0c, 32'(l));
			wr(6'h10, 32'(l));
			frame();
			chk(32'(seen.lane_enable), 32'(le[l]));
			chk(32'(seen.strobe_clock_source), 32'(l));
		end
		wr(6'h0c, 32'h0);
		wr(6'h08, 32'h40);
		frame();
		chk(32'(seen.lane_enable), 32'hff);
		$display("test lanes done");
	endtask

	task automatic t_error();
		rd(6'h14);
		chk(32'(r), 32'(APL_RESP_SLVERR));
		wr(6'h14, 32'h1);
		chk(32'(r), 32'(APL_RESP_SLVERR));
		rd(6'h06);
		chk(32'(r), 32'(APL_RESP_SLVERR));
		wr(6'h20, 32'h0);
		chk(32'(r), 32'(APL_RESP_SLVERR));
		wstrb <= 4'h0;
		wr(6'h04, 32'h20);
		wstrb <= 4'h1;
		chk(32'(r), 32'(APL_RESP_OKAY));
		chk(32'(pwr), 32'h5);
		$display("test errors done");
	endtask

	// ==========================================================
	// Verdict and run control.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// The tests need a few hundred cycles; twenty thousand means a hang.
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_power();
		t_proto();
		t_lane();
		t_error();
		stop_test();
	end
endmodule
